// ==== pic_pkg.sv ====
// Package with register map, field layout, reset values and types of the interrupt controller.
// Overview of operation
// - Sixteen inputs 0-15, each with fixed position, absolute and relative priority.
// - Fixed levels: 0-4 at 0, 5-7 at 1, 8 at 2, 9 at 5, 15 at 7.
// - Level 0 is most urgent, level 7 least urgent.
// - Each pending input's absolute level is compared against the core's current level.
// - Equal absolute levels: smallest relative priority value is issued first.
// - Core level 0 in user mode is treated as level 1.
// - Inputs 0 and 1 are issued as jumps, all others as calls.
// - Vectors in far page zero: offset 80 for input 0, step 8, F8 for 15.
// - Inputs 0-4 abort the current instruction; 2-4 give no return.
// - Inputs 0-6 can never be disabled by any mask setting.
// - Inputs 10-14 take level from 2-bit field: 00->3, 01->4, 10->5, 11->6.
// - Mask bit 0 hides an input, 1 exposes it; mask resets to 0.
// - Pending bit sets on event and stays readable while masked.
// - Pending writes never set; writing 1 clears and discards, 0 leaves unchanged.
// - Pending bit 0 maps to input 5, bit 10 to input 15.
// - Reset input fires at power-on and on watchdog reset request.
// - Stack fault raises only the stack input, not access or location errors.
package pic_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int NUM_INPUTS  = 16;
    localparam int PORT_WIDTH  = 11;
    localparam int PORT_BASE   = 5;
    localparam int ADDR_WIDTH  = 18;

    // ------------------------------------------------------------
    // Register indices; the byte address is four times the index
    // ------------------------------------------------------------
    localparam logic [15:0] IDX_PRIO_LOW   = 16'hE004;
    localparam logic [15:0] IDX_PRIO_HIGH  = 16'hE005;
    localparam logic [15:0] IDX_MASK_LOW   = 16'hE006;
    localparam logic [15:0] IDX_MASK_HIGH  = 16'hE007;
    localparam logic [15:0] IDX_WAITING_PORT_LOW   = 16'hE008;
    localparam logic [15:0] IDX_WAITING_PORT_HIGH  = 16'hE009;
    localparam logic [15:0] IDX_EVT_STATUS = 16'hE00A;
    localparam logic [15:0] IDX_EVT_MASK   = 16'hE00B;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [9:0]  PRIO_RESET     = 10'h000;
    localparam logic [10:0] MASK_RESET     = 11'h000;
    localparam logic [15:0] WAITING_PORT_RESET     = 16'h0001;
    localparam logic [2:0]  EVT_RESET      = 3'h0;

    // ------------------------------------------------------------
    // Levels, vectors and event status bits
    // ------------------------------------------------------------
    localparam logic [2:0]  FIELD_LEVEL_BASE = 3'h3;
    localparam logic [2:0]  USER_FLOOR_LEVEL = 3'h1;
    localparam logic [7:0]  VECTOR_BASE      = 8'h80;
    localparam int          VECTOR_SHIFT     = 3;
    localparam int          EVT_TAKEN        = 0;
    localparam int          EVT_FATAL        = 1;
    localparam int          EVT_OVERRUN      = 2;

    localparam int POS_RESTART  = 0;
    localparam int POS_STACK    = 1;
    localparam int POS_ACCESS   = 2;
    localparam int POS_LOCATION = 3;
    localparam int POS_LAST_ABORT = 4;

    typedef struct packed {
        logic       valid;
        logic       jump;
        logic       abort;
        logic       noReturn;
        logic [3:0] position;
        logic [7:0] vectorOffset;
        logic [2:0] level;
    } pic_issue_type;

endpackage

// ==== pic_controller.sv ====
// Prioritizing interrupt controller with APB register file and vectored request port to the core.
//
// The APB slave port was left to the implementer.
module pic_controller
    import pic_pkg::*;
(
    input  wire logic                  mclk,
    input  wire logic                  rst_n,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [ADDR_WIDTH-1:0] paddr,
    input  wire logic [31:0]           pwdata,
    output logic [31:0]                prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic [NUM_INPUTS-1:0] sourceIrq,
    input  wire logic                  watchdogRestartReq,
    input  wire logic [2:0]            coreLevel,
    input  wire logic                  coreUserMode,
    input  wire logic                  coreAck,
    output pic_issue_type              issueReq,
    output logic                       irqOut
);

    // ------------------------------------------------------------
    // Decoding helpers
    // ------------------------------------------------------------
    function automatic logic [2:0] fieldLevel(input logic [1:0] field);
        fieldLevel = FIELD_LEVEL_BASE + {1'b0, field};
    endfunction

    function automatic logic hitIndex(input logic [ADDR_WIDTH-1:0] addr, input logic [15:0] idx);
        hitIndex = (addr == {idx, 2'b00});
    endfunction

    function automatic logic [2:0] relLevel(input int pos);
        case (pos)
            1, 6, 11:  relLevel = 3'h1;
            2, 7, 12:  relLevel = 3'h2;
            3, 13:     relLevel = 3'h3;
            4, 14:     relLevel = 3'h4;
            default:   relLevel = 3'h0;
        endcase
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [9:0]            prioR;
    logic [10:0]           maskR;
    logic [15:0]           pendR;
    logic [15:0]           pendNxt;
    logic [2:0]            evtR;
    logic [2:0]            evtNxt;
    logic [2:0]            evtMaskR;
    logic [NUM_INPUTS-1:0] srcMetaR;
    logic [NUM_INPUTS-1:0] srcSyncR;
    logic [NUM_INPUTS-1:0] srcLastR;
    logic                  wdMetaR;
    logic                  wdSyncR;
    logic                  wdLastR;
    pic_issue_type         issueR;
    pic_issue_type         issueNxt;
    logic                  readyR;
    logic                  errR;
    logic [31:0]           rdataR;

    // ------------------------------------------------------------
    // Input synchronisers and edge detection
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            srcMetaR <= '0;
            srcSyncR <= '0;
            srcLastR <= '0;
            wdMetaR  <= 1'b0;
            wdSyncR  <= 1'b0;
            wdLastR  <= 1'b0;
        end
        else
        begin
            srcMetaR <= sourceIrq;
            srcSyncR <= srcMetaR;
            srcLastR <= srcSyncR;
            wdMetaR  <= watchdogRestartReq;
            wdSyncR  <= wdMetaR;
            wdLastR  <= wdSyncR;
        end
    end

    wire logic [NUM_INPUTS-1:0] srcRise   = srcSyncR & ~srcLastR;
    wire logic                  wdRise    = wdSyncR & ~wdLastR;
    wire logic                  stackRise = srcRise[POS_STACK];

    // A stack fault usually trips the access and location checks as well.
    // Those are dropped so that only the stack handler runs.
    logic [NUM_INPUTS-1:0] eventIn;
    always_comb
    begin
        eventIn = srcRise;
        eventIn[POS_RESTART] = srcRise[POS_RESTART] | wdRise;
        if (stackRise)
        begin
            eventIn[POS_ACCESS]   = 1'b0;
            eventIn[POS_LOCATION] = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    wire logic accessPhase = psel & penable;
    wire logic doneCycle   = accessPhase & readyR;
    wire logic hitPrioL    = hitIndex(paddr, IDX_PRIO_LOW);
    wire logic hitPrioH    = hitIndex(paddr, IDX_PRIO_HIGH);
    wire logic hitMaskL    = hitIndex(paddr, IDX_MASK_LOW);
    wire logic hitMaskH    = hitIndex(paddr, IDX_MASK_HIGH);
    wire logic hitPendL    = hitIndex(paddr, IDX_WAITING_PORT_LOW);
    wire logic hitPendH    = hitIndex(paddr, IDX_WAITING_PORT_HIGH);
    wire logic hitEvt      = hitIndex(paddr, IDX_EVT_STATUS);
    wire logic hitEvtMask  = hitIndex(paddr, IDX_EVT_MASK);
    wire logic anyHit      = hitPrioL | hitPrioH | hitMaskL | hitMaskH | hitPendL | hitPendH | hitEvt | hitEvtMask;
    wire logic wrDone      = doneCycle & pwrite & anyHit;
    wire logic rdDone      = doneCycle & ~pwrite & anyHit;

    logic [7:0] readMux;
    always_comb
    begin
        readMux = 8'h00;
        if (hitPrioL)
            readMux = prioR[7:0];
        else if (hitPrioH)
            readMux = {6'h00, prioR[9:8]};
        else if (hitMaskL)
            readMux = maskR[7:0];
        else if (hitMaskH)
            readMux = {5'h00, maskR[10:8]};
        else if (hitPendL)
            readMux = pendR[12:5];
        else if (hitPendH)
            readMux = {5'h00, pendR[15:13]};
        else if (hitEvt)
            readMux = {5'h00, evtR};
        else if (hitEvtMask)
            readMux = {5'h00, evtMaskR};
    end

    // One wait state: the read value and the error flag are captured at the edge where
    // pready rises, so both leave the block from flip-flops.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            readyR <= 1'b0;
            errR   <= 1'b0;
            rdataR <= 32'h0000_0000;
        end
        else
        begin
            readyR <= accessPhase & ~readyR;
            errR   <= accessPhase & ~readyR & ~anyHit;
            rdataR <= {24'h00_0000, readMux};
        end
    end

    assign pready  = readyR;
    assign pslverr = readyR & errR;
    assign prdata  = rdataR;

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prioR    <= PRIO_RESET;
            maskR    <= MASK_RESET;
            evtMaskR <= EVT_RESET;
        end
        else if (wrDone)
        begin
            if (hitPrioL)
                prioR[7:0] <= pwdata[7:0];
            if (hitPrioH)
                prioR[9:8] <= pwdata[1:0];
            if (hitMaskL)
                maskR[7:0] <= pwdata[7:0];
            if (hitMaskH)
                maskR[10:8] <= pwdata[2:0];
            if (hitEvtMask)
                evtMaskR <= pwdata[2:0];
        end
    end

    // ------------------------------------------------------------
    // Levels and eligibility
    // ------------------------------------------------------------
    logic [2:0] absLevel [NUM_INPUTS];
    genvar g;
    generate
        for (g = 0; g < NUM_INPUTS; g++)
        begin : g_level
            if (g <= POS_LAST_ABORT)
                assign absLevel[g] = 3'h0;
            else if (g <= 7)
                assign absLevel[g] = 3'h1;
            else if (g == 8)
                assign absLevel[g] = 3'h2;
            else if (g == 9)
                assign absLevel[g] = 3'h5;
            else if (g <= 14)
                assign absLevel[g] = fieldLevel(prioR[2*(g-10)+1 -: 2]);
            else
                assign absLevel[g] = 3'h7;
        end
    endgenerate

    // Inputs 0 to 6 are always enabled; mask bits 0 and 1 are stored but ignored.
    wire logic [15:0] enableEff = {maskR[10:2], 7'h7F};

    wire logic [2:0] effLevel = (coreLevel == 3'h0 && coreUserMode) ? USER_FLOOR_LEVEL : coreLevel;

    logic [NUM_INPUTS-1:0] eligible;
    always_comb
    begin
        for (int i = 0; i < NUM_INPUTS; i++)
            eligible[i] = pendR[i] & enableEff[i] & (absLevel[i] < effLevel);
    end

    // ------------------------------------------------------------
    // Winner search
    // ------------------------------------------------------------
    logic       bestFound;
    logic [5:0] bestKey;
    logic [3:0] bestPos;
    always_comb
    begin
        bestFound = 1'b0;
        bestKey   = 6'h3F;
        bestPos   = 4'h0;
        for (int i = 0; i < NUM_INPUTS; i++)
        begin
            // Strict compare keeps the lower position on an equal key, so the order is unique.
            if (eligible[i] && (!bestFound || {absLevel[i], relLevel(i)} < bestKey))
            begin
                bestFound = 1'b1;
                bestKey   = {absLevel[i], relLevel(i)};
                bestPos   = 4'(i);
            end
        end
    end

    // ------------------------------------------------------------
    // Request to the core
    // ------------------------------------------------------------
    always_comb
    begin
        issueNxt = issueR;
        if (issueR.valid)
        begin
            if (coreAck)
                issueNxt.valid = 1'b0;
        end
        else if (bestFound)
        begin
            issueNxt.valid        = 1'b1;
            issueNxt.jump         = (bestPos <= 4'(POS_STACK));
            issueNxt.abort        = (bestPos <= 4'(POS_LAST_ABORT));
            issueNxt.noReturn     = (bestPos >= 4'(POS_ACCESS)) && (bestPos <= 4'(POS_LAST_ABORT));
            issueNxt.position     = bestPos;
            issueNxt.vectorOffset = VECTOR_BASE + {1'b0, bestPos, 3'b000};
            issueNxt.level        = bestKey[5:3];
        end
    end

    wire logic taken = issueR.valid & coreAck;

    // ------------------------------------------------------------
    // Pending bits: hardware set wins over software or acknowledge clear
    // ------------------------------------------------------------
    logic [15:0] swClear;
    always_comb
    begin
        swClear = 16'h0000;
        if (wrDone && hitPendL)
            swClear[12:5] = pwdata[7:0];
        if (wrDone && hitPendH)
            swClear[15:13] = pwdata[2:0];
        pendNxt = pendR & ~swClear;
        if (taken)
            pendNxt[issueR.position] = 1'b0;
        pendNxt = pendNxt | eventIn;
    end

    // ------------------------------------------------------------
    // Event status: read clears, a new event in the same cycle survives
    // ------------------------------------------------------------
    always_comb
    begin
        evtNxt = (rdDone && hitEvt) ? 3'h0 : evtR;
        evtNxt[EVT_TAKEN]   = evtNxt[EVT_TAKEN] | taken;
        evtNxt[EVT_FATAL]   = evtNxt[EVT_FATAL] | (|eventIn[POS_LAST_ABORT:0]);
        evtNxt[EVT_OVERRUN] = evtNxt[EVT_OVERRUN] | (|(eventIn & pendR));
    end

    // Power-on reset leaves the restart input pending, so the core is sent to
    // the restart vector as soon as its level allows it.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pendR  <= WAITING_PORT_RESET;
            evtR   <= EVT_RESET;
            issueR <= '0;
        end
        else
        begin
            pendR  <= pendNxt;
            evtR   <= evtNxt;
            issueR <= issueNxt;
        end
    end

    assign issueReq = issueR;
    assign irqOut   = |(evtR & evtMaskR);

endmodule

// ==== pic_asserts.sv ====
// Port-level checks on the interrupt controller, bound into every instance.
module pic_asserts
    import pic_pkg::*;
(
    input wire logic          mclk,
    input wire logic          rst_n,
    input wire logic          psel,
    input wire logic          penable,
    input wire logic [31:0]   prdata,
    input wire logic          pready,
    input wire logic          pslverr,
    input wire logic [2:0]    coreLevel,
    input wire logic          coreUserMode,
    input wire logic          coreAck,
    input pic_issue_type      issueReq
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----
    // Relations
    // ----
    default clocking @(posedge mclk);
    endclocking
    default disable iff (!rst_n);
    logic [2:0] effLevel;
    assign effLevel = (coreUserMode && coreLevel == 3'h0) ? 3'h1 : coreLevel;
    function automatic logic [2:0] fixedLevel(input logic [3:0] p);
        if (p < 5)
            return 3'h0;
        if (p < 8)
            return 3'h1;
        if (p == 8)
            return 3'h2;
        return (p == 9) ? 3'h5 : 3'h7;
    endfunction
    sequence setupS;
        psel && !penable;
    endsequence
    sequence accessS;
        psel && penable;
    endsequence
    pready_wait_a: assert property (setupS ##1 accessS |-> !pready ##1 pready)
        else $error("pready not in second access cycle");
    err_data_a: assert property (pready && pslverr |-> prdata == 32'h0)
        else $error("refused access returned data");
    vector_step_a: assert property (issueReq.valid |-> issueReq.vectorOffset == 8'h80 + {1'b0, issueReq.position, 3'h0})
        else $error("vector offset wrong");
    jump_kind_a: assert property (issueReq.valid |-> issueReq.jump == (issueReq.position < 2))
        else $error("jump or call kind wrong");
    abort_kind_a: assert property (issueReq.valid |-> issueReq.abort == (issueReq.position < 5)
        && issueReq.noReturn == (issueReq.position inside {[2:4]}))
        else $error("abort flags wrong");
    fixed_level_a: assert property (issueReq.valid && !(issueReq.position inside {[10:14]})
        |-> issueReq.level == fixedLevel(issueReq.position))
        else $error("fixed level wrong");
    urgent_only_a: assert property ($rose(issueReq.valid) |-> issueReq.level < $past(effLevel))
        else $error("request not more urgent than core");
    hold_request_a: assert property (issueReq.valid && !coreAck |=> $stable(issueReq))
        else $error("request changed before acknowledge");
    ack_drop_a: assert property (issueReq.valid && coreAck |=> !issueReq.valid)
        else $error("request stayed after acknowledge");
endmodule

bind pic_controller pic_asserts chk (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .coreLevel(coreLevel),
    .coreUserMode(coreUserMode), .coreAck(coreAck), .issueReq(issueReq));

// ==== pic_core_model.sv ====
// Processor core model that takes vectored requests after a chosen delay.
module pic_core_model
    import pic_pkg::*;
(
    input wire logic          mclk,
    input wire logic          rst_n,
    input pic_issue_type      issueReq,
    input wire logic [1:0]    ackDelay,
    output logic              coreAck
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] waitCount_r;
    // The acknowledge is a single pulse, so a request is never taken twice.
    always_ff @(posedge mclk or negedge rst_n)
        if (!rst_n)
        begin
            coreAck     <= 1'b0;
            waitCount_r <= 2'h0;
        end
        else if (coreAck)
        begin
            coreAck     <= 1'b0;
            waitCount_r <= 2'h0;
        end
        else if (issueReq.valid)
        begin
            if (waitCount_r == ackDelay)
                coreAck <= 1'b1;
            else
                waitCount_r <= waitCount_r + 2'h1;
        end
endmodule

// ==== pic_controller_test.sv ====
// Self-checking bench of the interrupt controller with a core model on its request port.
module pic_controller_test
    import pic_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [17:0] aPl = {IDX_PRIO_LOW, 2'b00};
    localparam logic [17:0] aPh = {IDX_PRIO_HIGH, 2'b00};
    localparam logic [17:0] aMl = {IDX_MASK_LOW, 2'b00};
    localparam logic [17:0] aMh = {IDX_MASK_HIGH, 2'b00};
    localparam logic [17:0] aWl = {IDX_WAITING_PORT_LOW, 2'b00};
    localparam logic [17:0] aWh = {IDX_WAITING_PORT_HIGH, 2'b00};
    localparam logic [17:0] aEs = {IDX_EVT_STATUS, 2'b00};
    localparam logic [17:0] aEm = {IDX_EVT_MASK, 2'b00};
    logic mclk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [17:0] paddr = 18'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, irqOut, coreAck, er;
    logic [15:0] sourceIrq = 16'h0;
    logic wdReq = 1'b0, coreUserMode = 1'b0;
    logic [2:0] coreLevel = 3'h7;
    logic [1:0] ackDelay = 2'h0;
    logic [9:0] fld = 10'h0;
    pic_issue_type issueReq, expQ[$];
    int badCount = 0, nTests = 0, cyc = 0;
    pic_controller dut (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sourceIrq(sourceIrq), .watchdogRestartReq(wdReq), .coreLevel(coreLevel),
        .coreUserMode(coreUserMode), .coreAck(coreAck), .issueReq(issueReq), .irqOut(irqOut));
    pic_core_model core (.mclk(mclk), .rst_n(rst_n), .issueReq(issueReq), .ackDelay(ackDelay),
        .coreAck(coreAck));
    always #2 mclk = ~mclk;
    // ----
    // Tasks
    // ----
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        nTests++;
        if (seen !== exp)
        begin
            badCount++;
            $display("Error at %0t: seen 0x%0h expected 0x%0h", $time, seen, exp);
        end
    endtask
    task automatic closeOut;
        $display("Checks %0d, mismatches %0d", nTests, badCount);
        if (badCount == 0 && nTests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [17:0] a, input logic [7:0] d);
        @(posedge mclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= {24'h0, d};
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1)
            @(posedge mclk);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdc(input logic [17:0] a, input logic [7:0] e);
        apb(1'b0, a, 8'h00);
        chk(rd, {24'h0, e});
    endtask
    task automatic fire(input logic [15:0] m);
        @(posedge mclk);
        sourceIrq <= m;
        repeat (4) @(posedge mclk);
        sourceIrq <= 16'h0;
        repeat (4) @(posedge mclk);
    endtask
    task automatic drain;
        while (expQ.size() != 0)
            @(posedge mclk);
        repeat (4) @(posedge mclk);
    endtask
    function automatic pic_issue_type ex(input logic [3:0] p, input logic [2:0] l);
        ex = '{1'b1, p < 2, p < 5, p > 1 && p < 5, p, 8'h80 + {1'b0, p, 3'h0}, l};
    endfunction
    // The oldest note is compared at the edge where the core takes a request.
    always @(posedge mclk)
        if (rst_n && coreAck === 1'b1 && issueReq.valid === 1'b1)
        begin
            if (expQ.size() == 0)
                chk(32'(issueReq), 32'hFFFFFFFF);
            else
                chk(32'(issueReq), 32'(expQ.pop_front()));
        end
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 6000)
        begin
            badCount++;
            closeOut();
        end
    end
    initial
    begin
        void'($urandom(32'hF73C));
        expQ.push_back(ex(4'h0, 3'h0));
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        rdc(aPl, 8'h00);
        rdc(aMl, 8'h00);
        rdc(aWl, 8'h00);
        apb(1'b0, 18'h38030, 8'h00);
        chk({31'h0, er}, 32'h1);
        chk(rd, 32'h0);
        apb(1'b1, aMl, 8'hFF);
        apb(1'b1, aMh, 8'h07);
        rdc(aMh, 8'h07);
        coreLevel <= 3'h0;
        fire(16'h0200);
        rdc(aWl, 8'h10);
        expQ.push_back(ex(4'h9, 3'h5));
        coreLevel <= 3'h7;
        drain();
        fld = 10'($urandom);
        ackDelay <= 2'($urandom);
        apb(1'b1, aPl, fld[7:0]);
        apb(1'b1, aPh, {6'h0, fld[9:8]});
        for (int l = 3; l < 7; l++)
            for (int p = 10; p < 15; p++)
                if (3 + fld[2*(p-10) +: 2] == l)
                    expQ.push_back(ex(4'(p), 3'(l)));
        fire(16'h7C00);
        drain();
        coreLevel <= 3'h2;
        coreUserMode <= 1'b1;
        apb(1'b1, aMl, 8'h04);
        for (int p = 5; p < 8; p++)
            expQ.push_back(ex(4'(p), 3'h1));
        fire(16'h03E0);
        drain();
        rdc(aWl, 8'h18);
        apb(1'b1, aWl, 8'h10);
        apb(1'b1, aWl, 8'h00);
        rdc(aWl, 8'h08);
        coreUserMode <= 1'b0;
        coreLevel <= 3'h7;
        apb(1'b1, aMh, 8'h00);
        fire(16'h2000);
        rdc(aWh, 8'h01);
        expQ.push_back(ex(4'hD, 3'(3 + fld[7:6])));
        apb(1'b1, aMh, 8'h01);
        drain();
        coreLevel <= 3'h0;
        coreUserMode <= 1'b1;
        apb(1'b1, aEm, 8'h02);
        apb(1'b0, aEs, 8'h00);
        expQ.push_back(ex(4'h1, 3'h0));
        fire(16'h000E);
        drain();
        chk({31'h0, irqOut}, 32'h1);
        rdc(aEs, 8'h03);
        repeat (2) @(posedge mclk);
        chk({31'h0, irqOut}, 32'h0);
        coreUserMode <= 1'b0;
        coreLevel <= 3'h7;
        expQ.push_back(ex(4'h0, 3'h0));
        @(posedge mclk);
        wdReq <= 1'b1;
        repeat (4) @(posedge mclk);
        wdReq <= 1'b0;
        drain();
        chk(32'(expQ.size()), 32'h0);
        closeOut();
    end
endmodule
